// ### dv/acf_core_props.sv
`timescale 1ns/10ps
`default_nettype none
module acf_core_props (
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // register port
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_rdata_ff,
    // conversion and analog side
    input wire logic conv_busy,
    input wire logic conv_done_ff,
    input wire logic sar_clk_tick,
    input wire logic gain_unity,
    input wire logic eight_bit_mode
);
    logic [7:0] cfg_ff;
    logic [4:0] gap_ff;
    logic seen_ff;
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    // config shadow and tick spacing; first tick unchecked, its lead-in is a design choice
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            cfg_ff <= 8'hf9;
            gap_ff <= 5'h00;
            seen_ff <= 1'b0;
        end
        else
        begin
            if (sfr_wr && sfr_addr == 8'hbc)
                cfg_ff <= sfr_wdata;
            gap_ff <= sar_clk_tick ? 5'h00 : gap_ff + 5'h01;
            seen_ff <= conv_busy && (seen_ff || sar_clk_tick);
        end
    end
    sequence busy_end;
        conv_busy ##1 !conv_busy;
    endsequence
    tick_gap_a: assert property (sar_clk_tick && seen_ff |-> gap_ff == cfg_ff[7:3])
        else $error("converter tick spacing wrong");
    tick_idle_a: assert property (!conv_busy |-> !sar_clk_tick)
        else $error("tick while idle");
    done_end_a: assert property (busy_end |-> conv_done_ff)
        else $error("no done when busy ends");
    done_pulse_a: assert property (conv_done_ff |=> !conv_done_ff)
        else $error("done longer than one cycle");
    mode_map_a: assert property (eight_bit_mode == cfg_ff[1] && gain_unity == cfg_ff[0])
        else $error("mode outputs differ from config");
    cfg_read_a: assert property (sfr_rd && sfr_addr == 8'hbc |=> sfr_rdata_ff == $past(cfg_ff))
        else $error("config readback wrong");
    unmapped_rd_a: assert property (sfr_rd && !(sfr_addr inside {8'hbc, 8'hbd, 8'hbe}) |=> sfr_rdata_ff == 8'h00)
        else $error("unmapped read not zero");
    conv_bound_a: assert property ($rose(conv_busy) |-> ##[1:400] conv_done_ff)
        else $error("conversion never completed");
endmodule // acf_core_props
bind acf_core acf_core_props acf_core_props_i (.mclk(mclk), .reset(reset), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata_ff(sfr_rdata_ff),
    .conv_busy(conv_busy), .conv_done_ff(conv_done_ff), .sar_clk_tick(sar_clk_tick),
    .gain_unity(gain_unity), .eight_bit_mode(eight_bit_mode));
`default_nettype wire

// ### dv/acf_core_test.sv
`timescale 1ns/10ps
`default_nettype none
module acf_core_test;
    logic mclk = 0, reset = 1, sfr_wr = 0, sfr_rd = 0, conv_start = 0;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata_ff;
    logic [9:0] target = 10'h000, sar_trial_ff;
    logic sar_cmp, conv_busy, conv_done_ff, sar_clk_tick, sar_sample, gain_unity, eight_bit_mode;
    int num_errors = 0, n_tests = 0, cyc = 0, t10, t8;
    initial forever #5 mclk = ~mclk;
    acf_core acf_core_i (.mclk(mclk), .reset(reset), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata_ff(sfr_rdata_ff), .conv_start(conv_start),
        .conv_busy(conv_busy), .conv_done_ff(conv_done_ff), .sar_cmp(sar_cmp), .sar_trial_ff(sar_trial_ff),
        .sar_clk_tick(sar_clk_tick), .sar_sample(sar_sample), .gain_unity(gain_unity),
        .eight_bit_mode(eight_bit_mode));
    acf_sar_model acf_sar_model_i (.sar_trial_ff(sar_trial_ff), .target(target), .sar_cmp(sar_cmp));
    task summarize();
        $display("errors %0d of %0d checks", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task chk(input string what, input logic [9:0] exp, input logic [9:0] got);
        n_tests++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] %s exp %h got %h", what, exp, got);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1;
        @(posedge mclk);
        sfr_wr <= 0;
    endtask
    // read data is registered on the taking edge and checked just after it
    task rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk);
        sfr_addr <= a;
        sfr_rd <= 1;
        @(posedge mclk);
        sfr_rd <= 0;
        #1 chk(what, {2'b00, exp}, {2'b00, sfr_rdata_ff});
    endtask
    task conv(input logic [9:0] tv, output int n);
        target = tv;
        @(posedge mclk);
        conv_start <= 1;
        @(posedge mclk);
        conv_start <= 0;
        n = 0;
        #1;
        chk("busy at start", 10'h001, {9'h000, conv_busy});
        chk("tracking", 10'h001, {9'h000, sar_sample});
        while (conv_done_ff !== 1'b1 && n < 1000)
        begin
            @(posedge mclk);
            #1 n++;
        end
        chk("busy at done", 10'h000, {9'h000, conv_busy});
    endtask
    task t_reset();
        rchk("cfg reset", 8'hbc, 8'hf9);
        rchk("lo reset", 8'hbd, 8'h00);
        rchk("hi reset", 8'hbe, 8'h00);
        rchk("unmapped", 8'hbf, 8'h00);
        chk("gain reset", 10'h001, {9'h000, gain_unity});
        wr(8'hbd, 8'h5a);
        rchk("lo write", 8'hbd, 8'h5a);
        wr(8'hbe, 8'ha5);
        rchk("hi write", 8'hbe, 8'ha5);
    endtask
    task t_right();
        wr(8'hbc, 8'h10);
        #1 chk("gain half", 10'h000, {9'h000, gain_unity});
        conv(10'h2d6, t10);
        rchk("hi right", 8'hbe, 8'h02);
        rchk("lo right", 8'hbd, 8'hd6);
    endtask
    task t_left();
        wr(8'hbc, 8'h14);
        conv(10'h2d6, t10);
        rchk("hi left", 8'hbe, 8'hb5);
        rchk("lo left", 8'hbd, 8'h80);
    endtask
    // left select stays set; with the two low bits zero it reads the same as the 8-bit layout
    task t_eight();
        wr(8'hbc, 8'h16);
        #1 chk("eight mode", 10'h001, {9'h000, eight_bit_mode});
        conv(10'h2d6, t8);
        rchk("hi eight", 8'hbe, 8'hb5);
        rchk("lo eight", 8'hbd, 8'h00);
        chk("cycles saved", 10'h006, 10'(t10 - t8));
    endtask
    // hang guard, whole run needs about 140 cycles
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            num_errors++;
            summarize();
        end
    end
    initial
    begin
        repeat (4) @(posedge mclk);
        reset <= 0;
        t_reset();
        t_right();
        t_left();
        t_eight();
        summarize();
    end
endmodule // acf_core_test
`default_nettype wire

// ### dv/acf_sar_model.sv
`timescale 1ns/10ps
`default_nettype none
module acf_sar_model (
    // trial code and held input level
    input wire logic [9:0] sar_trial_ff,
    input wire logic [9:0] target,
    // comparator answer
    output logic sar_cmp
);
    // ideal comparator, so a 10-bit search settles exactly on the target
    assign sar_cmp = (target >= sar_trial_ff);
endmodule // acf_sar_model
`default_nettype wire

// ### rtl/acf_clk_div.v
`timescale 1ns/10ps
`default_nettype none
module acf_clk_div #(
    parameter W = 5
) (
    // clock and reset
    input wire mclk,
    input wire reset,
    // divider setting and enable
    input wire [W-1:0] div_val,
    input wire run,
    // one-cycle converter clock tick
    output wire tick
);
    reg [W-1:0] cnt_ff;
    wire [W-1:0] nxt_cnt;

    // count up to the divider value, tick on the wrap; period is div_val+1
    assign tick = run && (cnt_ff >= div_val);
    assign nxt_cnt = (!run || tick) ? {W{1'b0}} : cnt_ff + {{(W-1){1'b0}}, 1'b1};

    // compare with >= so a divider lowered mid-count cannot stall the wrap
    always @(posedge mclk or posedge reset)
    begin
        if (reset)
            cnt_ff <= {W{1'b0}};
        else
            cnt_ff <= nxt_cnt;
    end
endmodule // acf_clk_div
`default_nettype wire

// ### rtl/acf_consts.vh
// Notes on behaviour
// - converter clock period is divider field plus one system clocks.
// - justify select zero gives right-justified, one gives left-justified results.
// - justify select applies only in 10-bit mode; ignored when 8-bit enabled.
// - resolution bit zero selects 10-bit, one selects 8-bit conversion.
// - gain bit zero selects gain 0.5, one selects unity gain.
// - right-justified high byte: zeros in 7:2, top two result bits in 1:0.
// - left-justified high byte holds eight most significant result bits.
// - in 8-bit mode high byte holds the full 8-bit result.
// - right-justified low byte holds lower eight result bits.
// - left-justified low byte: two low bits in 7:6, zeros in 5:0.
// - in 8-bit mode low byte reads all zeros.
// - both result bytes load the new code when a conversion completes.
// - 8-bit conversion takes two fewer converter clocks than 10-bit.
`ifndef ACF_CONSTS_VH
`define ACF_CONSTS_VH
`define ACF_ADDR_CONFIG 8'hbc
`define ACF_ADDR_RES_LO 8'hbd
`define ACF_ADDR_RES_HI 8'hbe
`define ACF_CONFIG_RST 8'hf9
`define ACF_RES_RST 8'h00
`define ACF_DIV_HI 7
`define ACF_DIV_LO 3
`define ACF_JUST_BIT 2
`define ACF_8B_BIT 1
`define ACF_GAIN_BIT 0
`define ACF_BITS_10 4'ha
`define ACF_BITS_8 4'h8
`define ACF_TRACK_CLKS 4'h1
`endif

// ### rtl/acf_core.v
`timescale 1ns/10ps
`default_nettype none
`include "acf_consts.vh"
module acf_core #(
    parameter DIV_W = 5,
    parameter RES_W = 10
) (
    // clock and reset
    input wire mclk,
    input wire reset,
    // special function register port
    input wire [7:0] sfr_addr,
    input wire [7:0] sfr_wdata,
    input wire sfr_wr,
    input wire sfr_rd,
    output reg [7:0] sfr_rdata_ff,
    // conversion control from the control logic
    input wire conv_start,
    output wire conv_busy,
    output reg conv_done_ff,
    // analog core side
    input wire sar_cmp,
    output reg [RES_W-1:0] sar_trial_ff,
    output wire sar_clk_tick,
    output wire sar_sample,
    output wire gain_unity,
    output wire eight_bit_mode
);
    // one-hot sequencer states
    localparam S_IDLE = 3'b001;
    localparam S_TRACK = 3'b010;
    localparam S_CONV = 3'b100;
    // one converter clock, the step of the track and bit counters
    localparam [3:0] ONE_CLK = 4'h1;
    // the two low code bits that only 10-bit mode resolves
    localparam LOW_W = 2;
    // width of a special function register
    localparam BYTE_W = 8;

    // software visible registers
    reg [7:0] cfg_ff;
    reg [7:0] res_hi_ff;
    reg [7:0] res_lo_ff;

    // sequencer state
    reg [2:0] state_ff;
    reg [3:0] bit_ff;
    reg [3:0] track_ff;
    reg [RES_W-1:0] acc_ff;
    reg eight_ff;

    // next values from the combinational processes
    reg [2:0] nxt_state;
    reg [3:0] nxt_bit;
    reg [3:0] nxt_track;
    reg [RES_W-1:0] nxt_acc;
    reg [RES_W-1:0] nxt_trial;
    reg nxt_done;
    reg nxt_eight;
    reg [7:0] fmt_hi;
    reg [7:0] fmt_lo;
    reg [7:0] nxt_rdata;

    // decoded fields, strobes and sequencer conditions
    wire [DIV_W-1:0] conv_clock_divider;
    wire justify_select;
    wire eight_bit_enable;
    wire gain_select;
    wire wr_cfg;
    wire wr_hi;
    wire wr_lo;
    wire busy;
    wire start_taken;
    wire last_track;
    wire last_bit;
    wire [RES_W-1:0] final_code;

    // configuration fields
    assign conv_clock_divider = cfg_ff[`ACF_DIV_HI:`ACF_DIV_LO];
    assign justify_select = cfg_ff[`ACF_JUST_BIT];
    assign eight_bit_enable = cfg_ff[`ACF_8B_BIT];
    assign gain_select = cfg_ff[`ACF_GAIN_BIT];
    assign gain_unity = gain_select;
    assign eight_bit_mode = eight_bit_enable;

    // one write strobe per register address
    assign wr_cfg = sfr_wr && (sfr_addr == `ACF_ADDR_CONFIG);
    assign wr_lo = sfr_wr && (sfr_addr == `ACF_ADDR_RES_LO);
    assign wr_hi = sfr_wr && (sfr_addr == `ACF_ADDR_RES_HI);

    // status for the control logic and the analog core
    assign busy = (state_ff != S_IDLE);
    assign conv_busy = busy;
    assign sar_sample = (state_ff == S_TRACK);

    // sequencer conditions; start_taken is also used by the resolution latch
    assign start_taken = (state_ff == S_IDLE) && conv_start;
    assign last_track = (track_ff == ONE_CLK);
    assign last_bit = (bit_ff == ONE_CLK);

    // converter clock divider; runs only while a conversion is under way,
    // so every conversion begins with a full converter clock period
    acf_clk_div #(
        .W(DIV_W)
    ) u_div (
        .mclk(mclk),
        .reset(reset),
        .div_val(conv_clock_divider),
        .run(busy),
        .tick(sar_clk_tick)
    );

    // config register; resolution is latched per conversion so a write
    // during a conversion cannot corrupt the bit sequence
    always @(posedge mclk or posedge reset)
    begin
        if (reset)
            cfg_ff <= `ACF_CONFIG_RST;
        else if (wr_cfg)
            cfg_ff <= sfr_wdata;
    end

    // successive approximation sequencer, one bit per converter clock;
    // a start spends one converter clock tracking, then tries each bit
    // from the top down and the comparator keeps or drops the trial bit;
    // 8-bit mode stops two bits early, so its code sits in the top bits
    // and the two low bits stay zero
    always @*
    begin
        nxt_state = state_ff;
        nxt_bit = bit_ff;
        nxt_track = track_ff;
        nxt_acc = acc_ff;
        nxt_trial = sar_trial_ff;
        nxt_done = 1'b0;
        case (state_ff)
            S_IDLE:
            begin
                if (start_taken)
                begin
                    nxt_state = S_TRACK;
                    nxt_track = `ACF_TRACK_CLKS;
                    nxt_acc = {RES_W{1'b0}};
                    nxt_bit = eight_bit_enable ? `ACF_BITS_8 : `ACF_BITS_10;
                end
            end
            S_TRACK:
            begin
                if (sar_clk_tick)
                begin
                    nxt_track = track_ff - ONE_CLK;
                    if (last_track)
                    begin
                        nxt_state = S_CONV;
                        nxt_trial = {1'b1, {(RES_W-1){1'b0}}};
                    end
                end
            end
            S_CONV:
            begin
                if (sar_clk_tick)
                begin
                    // keep the trial bit if the comparator says input is above
                    nxt_acc = sar_cmp ? sar_trial_ff : acc_ff;
                    nxt_bit = bit_ff - ONE_CLK;
                    if (last_bit)
                    begin
                        nxt_state = S_IDLE;
                        nxt_done = 1'b1;
                        nxt_trial = {RES_W{1'b0}};
                    end
                    else
                        nxt_trial = nxt_acc | ((sar_trial_ff ^ acc_ff) >> 1);
                end
            end
            default:
                nxt_state = S_IDLE;
        endcase
    end

    always @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            state_ff <= S_IDLE;
            bit_ff <= 4'h0;
            track_ff <= 4'h0;
            conv_done_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            bit_ff <= nxt_bit;
            track_ff <= nxt_track;
            conv_done_ff <= nxt_done;
        end
    end

    // code accumulator and trial code; the trial is registered so the
    // comparator sees a settled code for a whole converter clock
    always @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            acc_ff <= {RES_W{1'b0}};
            sar_trial_ff <= {RES_W{1'b0}};
        end
        else
        begin
            acc_ff <= nxt_acc;
            sar_trial_ff <= nxt_trial;
        end
    end

    // resolution latched when a start is taken; a later config write
    // only affects the next conversion
    always @*
    begin
        nxt_eight = eight_ff;
        if (start_taken)
            nxt_eight = eight_bit_enable;
    end

    always @(posedge mclk or posedge reset)
    begin
        if (reset)
            eight_ff <= 1'b0;
        else
            eight_ff <= nxt_eight;
    end

    // finished code taken from the accumulator's next value, so the
    // bytes load on the done edge itself
    assign final_code = nxt_acc;

    // result formatting; 8-bit results sit in the top bits of the code
    always @*
    begin
        if (eight_ff)
        begin
            // whole 8-bit code in the high byte, low byte empty
            fmt_hi = final_code[RES_W-1:RES_W-BYTE_W];
            fmt_lo = {BYTE_W{1'b0}};
        end
        else if (justify_select)
        begin
            // left-justified: top eight bits high, two low bits on top of low
            fmt_hi = final_code[RES_W-1:RES_W-BYTE_W];
            fmt_lo = {final_code[LOW_W-1:0], {(BYTE_W-LOW_W){1'b0}}};
        end
        else
        begin
            // right-justified: two top bits at the bottom of the high byte
            fmt_hi = {{(BYTE_W-LOW_W){1'b0}}, final_code[RES_W-1:RES_W-LOW_W]};
            fmt_lo = final_code[BYTE_W-1:0];
        end
    end

    // result bytes: both load in one cycle at completion; a software write
    // loses to a completing conversion so no byte pair is mixed
    always @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            res_hi_ff <= `ACF_RES_RST;
            res_lo_ff <= `ACF_RES_RST;
        end
        else if (nxt_done)
        begin
            res_hi_ff <= fmt_hi;
            res_lo_ff <= fmt_lo;
        end
        else
        begin
            if (wr_hi)
                res_hi_ff <= sfr_wdata;
            if (wr_lo)
                res_lo_ff <= sfr_wdata;
        end
    end

    // registered read data; unmapped addresses read zero and a read has
    // no side effects, so software may poll freely
    always @*
    begin
        nxt_rdata = 8'h00;
        if (sfr_rd)
        begin
            case (sfr_addr)
                `ACF_ADDR_CONFIG: nxt_rdata = cfg_ff;
                `ACF_ADDR_RES_LO: nxt_rdata = res_lo_ff;
                `ACF_ADDR_RES_HI: nxt_rdata = res_hi_ff;
                default: nxt_rdata = 8'h00;
            endcase
        end
    end

    always @(posedge mclk or posedge reset)
    begin
        if (reset)
            sfr_rdata_ff <= 8'h00;
        else
            sfr_rdata_ff <= nxt_rdata;
    end
endmodule // acf_core
`default_nettype wire
